// ### hdl/ptr_regs.svh
// protection threshold register bank: command codes, reset values, limits
// assumes telemetry arrives already scaled: vout as vid code, iout in 1 a,
// temperature in 1 degc, vin in 1 mv, iin in 0.5 a steps
//------------------------------------------------------------
// Operation
//------------------------------------------------------------
// Operation
// [R1] output overvoltage threshold defaults to 1.520 v; fault latches off, no restart
// [R2] undervoltage threshold and minimum output default to 0.000 v; fault latches off
// [R3] output overcurrent fault defaults to 39 a per channel; fault latches off
// [R4] output overcurrent warning defaults to 26 a and only warns
// [R5] vin on 6.25 v, vin ov 14.00 v keeps running, vin uv 5.50 v latches off
// [R6] input overcurrent fault and warning both 63.5 a; fault latches off, warning flags
// [R7] overtemperature fault 135 degc latches off; warning 105 degc only warns
// [R8] overvoltage limit derives from maximum output plus offset, readable as vid code
// [R9] overvoltage response code is read-only; host writes cannot change it
// [R10] host reaches the overvoltage limit only with word reads or writes
// [R11] paged access: 00h channel a, 01h channel b, ffh both channels
// [R12] limit word carries the code in bits 7:0, upper bits read zero
// [R13] 5 mv dac table forces the limit code to ffh
// [R14] 10 mv dac table computes the code from maximum output plus offset
// [R15] sensed output voltage reaching the limit declares an overvoltage fault
// [R16] overvoltage fault latches off, sets status bits, alerts unless masked, response 80h
// [R17] host clears a latched fault by toggling enable or the on bit
// [R18] the offset between maximum output and limit codes is a fixed constant
`ifndef PTR_REGS_SVH
`define PTR_REGS_SVH
`define PTR_CMD_PAGE      8'h00
`define PTR_CMD_OPER      8'h01
`define PTR_CMD_VMAX      8'h24
`define PTR_CMD_OV_LIM    8'h40
`define PTR_CMD_OV_RESP   8'h41
`define PTR_CMD_ALRT_MSK  8'h1B
`define PTR_CMD_FLT_STAT  8'h7A
`define PTR_CMD_DAC_CFG   8'hD0
`define PTR_PAGE_A        8'h00
`define PTR_PAGE_B        8'h01
`define PTR_PAGE_ALL      8'hFF
`define PTR_OPER_ON_BIT   7
`define PTR_OPER_RST      1'b1
`define PTR_DAC5_RST      1'b1
`define PTR_VMAX_RST      8'hFF
`define PTR_MSK_RST       8'h00
`define PTR_OV_RESP_CODE  8'h80
`define PTR_OV_OFFSET     8'h0A
`define PTR_OV_LIM_5MV    8'hFF
`define PTR_UV_LIM        8'h00
`define PTR_VMIN          8'h00
`define PTR_OC_FLT        8'h27
`define PTR_OC_WRN        8'h1A
`define PTR_VIN_ON        16'h186A
`define PTR_VIN_OV        16'h36B0
`define PTR_VIN_UV        16'h157C
`define PTR_IIN_FLT       8'h7F
`define PTR_IIN_WRN       8'h7F
`define PTR_OT_FLT        8'h87
`define PTR_OT_WRN        8'h69
`endif

// ### hdl/ptr_pkg.sv
// types shared by the protection threshold bank and its bench
// assumes the constants of ptr_regs.svh
package ptr_pkg;
  typedef struct packed {
    logic        valid;
    logic        wr;
    logic        word;
    logic [7:0]  code;
    logic [15:0] wdata;
  } ptr_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        ack;
    logic [15:0] data;
  } ptr_rsp_t;

  typedef struct packed {
    logic [7:0]  vout_a;
    logic [7:0]  vout_b;
    logic [7:0]  iout_a;
    logic [7:0]  iout_b;
    logic [7:0]  temp_a;
    logic [7:0]  temp_b;
    logic [15:0] vin_mv;
    logic [7:0]  iin_half;
  } ptr_telem_t;

  typedef struct packed {
    logic ov;
    logic uv;
    logic oc;
    logic ot;
  } ptr_flt_t;

  typedef struct packed {
    logic oc_a;
    logic oc_b;
    logic ot_a;
    logic ot_b;
    logic iin;
    logic vin_ov;
  } ptr_warn_t;
endpackage

// ### hdl/ptr_top.sv
// protection threshold and response bank for a two-channel buck controller
// assumes a pmbus link layer on I_CLK hands over decoded commands; enable pins are async
`timescale 1ns/1ps
`include "ptr_regs.svh"
module ptr_top
  import ptr_pkg::*;
(
  input  wire logic       I_CLK,
  input  wire logic       I_NRST,
  input  wire ptr_cmd_t   I_CMD,
  input  wire ptr_telem_t I_TELEM,
  input  wire logic [1:0] I_CH_EN,
  output ptr_rsp_t        O_RSP,
  output ptr_flt_t        O_FLT_A,
  output ptr_flt_t        O_FLT_B,
  output logic            O_VIN_UV_FLT,
  output logic            O_IIN_FLT,
  output ptr_warn_t       O_WARN,
  output logic            O_VIN_OK,
  output logic [1:0]      O_SHDN,
  output logic            O_HOST_ALERT_LINE_N
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] ov_code(input logic dac5, input logic [7:0] vmax);
    logic [8:0] sum;
    sum = {1'b0, vmax} + {1'b0, `PTR_OV_OFFSET};                               // [R18]
    if (dac5) begin
      ov_code = `PTR_OV_LIM_5MV;                                                // [R13]
    end else if (sum[8]) begin
      ov_code = 8'hFF;
    end else begin
      ov_code = sum[7:0];                                                       // [R14]
    end
  endfunction

  function automatic ptr_flt_t ch_check(input logic [7:0] vout, input logic [7:0] lim,
                                        input logic [7:0] iout, input logic [7:0] temp);
    ch_check.ov = (vout >= lim);                                                // [R15]
    ch_check.uv = (vout < `PTR_UV_LIM) || (vout < `PTR_VMIN);                   // [R2]
    ch_check.oc = (iout >= `PTR_OC_FLT);                                        // [R3]
    ch_check.ot = (temp >= `PTR_OT_FLT);                                        // [R7]
  endfunction

  // ------------------------------------------------------------
  // enable pin synchroniser
  // ------------------------------------------------------------
  logic [1:0] en_meta_r;
  logic [1:0] en_sync_r;
  logic [1:0] run_d_r;
  logic [1:0] run;
  logic [1:0] clr;

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      en_meta_r <= 2'h0;
      en_sync_r <= 2'h0;
    end else begin
      en_meta_r <= I_CH_EN;
      en_sync_r <= en_meta_r;
    end
  end

  // ------------------------------------------------------------
  // command registers
  // ------------------------------------------------------------
  logic [7:0] page_r;
  logic [1:0] on_r;
  logic [7:0] vmax_a_r;
  logic [7:0] vmax_b_r;
  logic       dac5_r;
  logic [7:0] msk_r;
  logic       pg_ok;
  logic       sel_a;
  logic       sel_b;
  logic       wr_word;
  logic       wr_byte;

  assign pg_ok   = (page_r == `PTR_PAGE_A) || (page_r == `PTR_PAGE_B) || (page_r == `PTR_PAGE_ALL);
  assign sel_a   = (page_r == `PTR_PAGE_A) || (page_r == `PTR_PAGE_ALL);                  // [R11]
  assign sel_b   = (page_r == `PTR_PAGE_B) || (page_r == `PTR_PAGE_ALL);                  // [R11]
  assign wr_word = I_CMD.valid && I_CMD.wr && I_CMD.word;
  assign wr_byte = I_CMD.valid && I_CMD.wr && !I_CMD.word;

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      page_r <= `PTR_PAGE_A;
    end else if (wr_byte && I_CMD.code == `PTR_CMD_PAGE) begin
      page_r <= I_CMD.wdata[7:0];
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      on_r <= {2{`PTR_OPER_RST}};
    end else if (wr_byte && I_CMD.code == `PTR_CMD_OPER) begin
      if (sel_a) begin
        on_r[0] <= I_CMD.wdata[`PTR_OPER_ON_BIT];
      end
      if (sel_b) begin
        on_r[1] <= I_CMD.wdata[`PTR_OPER_ON_BIT];
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      vmax_a_r <= `PTR_VMAX_RST;
      vmax_b_r <= `PTR_VMAX_RST;
    end else if (wr_word && I_CMD.code == `PTR_CMD_VMAX) begin
      if (sel_a) begin
        vmax_a_r <= I_CMD.wdata[7:0];                                          // [R11]
      end
      if (sel_b) begin
        vmax_b_r <= I_CMD.wdata[7:0];                                          // [R11]
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      dac5_r <= `PTR_DAC5_RST;
      msk_r  <= `PTR_MSK_RST;
    end else if (wr_byte && I_CMD.code == `PTR_CMD_DAC_CFG) begin
      dac5_r <= I_CMD.wdata[0];
    end else if (wr_byte && I_CMD.code == `PTR_CMD_ALRT_MSK) begin
      msk_r  <= I_CMD.wdata[7:0];
    end
  end

  // ------------------------------------------------------------
  // limit derivation and comparison
  // ------------------------------------------------------------
  logic [7:0] lim_a;
  logic [7:0] lim_b;
  ptr_flt_t   hit_a;
  ptr_flt_t   hit_b;
  logic       vin_uv_hit;
  logic       iin_hit;

  assign lim_a      = ov_code(dac5_r, vmax_a_r);                                 // [R8]
  assign lim_b      = ov_code(dac5_r, vmax_b_r);                                 // [R8]
  assign hit_a      = ch_check(I_TELEM.vout_a, lim_a, I_TELEM.iout_a, I_TELEM.temp_a);
  assign hit_b      = ch_check(I_TELEM.vout_b, lim_b, I_TELEM.iout_b, I_TELEM.temp_b);
  assign vin_uv_hit = I_TELEM.vin_mv < `PTR_VIN_UV;                              // [R5]
  assign iin_hit    = I_TELEM.iin_half >= `PTR_IIN_FLT;                          // [R6]

  // ------------------------------------------------------------
  // latched faults
  // ------------------------------------------------------------
  // a fault stays latched until the channel is taken down (its run state falls);
  // a new hit in the clearing cycle wins so no event is lost
  assign run = en_sync_r & on_r;
  assign clr = run_d_r & ~run;                                                   // [R17]

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      run_d_r <= 2'h0;
    end else begin
      run_d_r <= run;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_FLT_A <= '0;
      O_FLT_B <= '0;
    end else begin
      O_FLT_A <= (clr[0] ? '0 : O_FLT_A) | hit_a;                               // [R1]
      O_FLT_B <= (clr[1] ? '0 : O_FLT_B) | hit_b;                               // [R16]
    end
  end

  // input side faults are shared, so either channel going down clears them
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_VIN_UV_FLT <= 1'b0;
      O_IIN_FLT    <= 1'b0;
    end else begin
      O_VIN_UV_FLT <= (O_VIN_UV_FLT && !(|clr)) || vin_uv_hit;                  // [R5]
      O_IIN_FLT    <= (O_IIN_FLT && !(|clr)) || iin_hit;                        // [R6]
    end
  end

  // ------------------------------------------------------------
  // warnings, shutdown and host alert
  // ------------------------------------------------------------
  logic [7:0] cause;
  logic       shared_flt;

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_WARN   <= '0;
      O_VIN_OK <= 1'b0;
    end else begin
      O_WARN.oc_a   <= I_TELEM.iout_a >= `PTR_OC_WRN;                           // [R4]
      O_WARN.oc_b   <= I_TELEM.iout_b >= `PTR_OC_WRN;                           // [R4]
      O_WARN.ot_a   <= I_TELEM.temp_a >= `PTR_OT_WRN;                           // [R7]
      O_WARN.ot_b   <= I_TELEM.temp_b >= `PTR_OT_WRN;                           // [R7]
      O_WARN.iin    <= I_TELEM.iin_half >= `PTR_IIN_WRN;                        // [R6]
      O_WARN.vin_ov <= I_TELEM.vin_mv > `PTR_VIN_OV;                            // [R5]
      O_VIN_OK      <= I_TELEM.vin_mv >= `PTR_VIN_ON;                           // [R5]
    end
  end

  // warnings never appear here: they only flag and alert
  assign shared_flt = O_VIN_UV_FLT || O_IIN_FLT;
  assign O_SHDN[0]  = (|O_FLT_A) || shared_flt;                                 // [R16]
  assign O_SHDN[1]  = (|O_FLT_B) || shared_flt;

  // mask bit set hides that cause from the alert line
  assign cause = {2'b00, |O_WARN, O_VIN_UV_FLT || O_IIN_FLT, O_FLT_A.ot || O_FLT_B.ot,
                  O_FLT_A.oc || O_FLT_B.oc, O_FLT_A.uv || O_FLT_B.uv, O_FLT_A.ov || O_FLT_B.ov};

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_HOST_ALERT_LINE_N <= 1'b1;
    end else begin
      O_HOST_ALERT_LINE_N <= !(|(cause & ~msk_r));                              // [R16]
    end
  end

  // ------------------------------------------------------------
  // command answers
  // ------------------------------------------------------------
  logic        ack_nxt;
  logic [15:0] rd_nxt;

  always_comb begin
    ack_nxt = 1'b1;
    rd_nxt  = 16'h0000;
    case (I_CMD.code)
      `PTR_CMD_PAGE: begin
        ack_nxt = !I_CMD.word;
        rd_nxt  = {8'h00, page_r};
      end
      `PTR_CMD_OPER: begin
        ack_nxt = !I_CMD.word && pg_ok;
        rd_nxt  = {8'h00, sel_a ? on_r[0] : on_r[1], 7'h00};
      end
      `PTR_CMD_VMAX: begin
        ack_nxt = I_CMD.word && pg_ok;
        rd_nxt  = {8'h00, sel_a ? vmax_a_r : vmax_b_r};
      end
      `PTR_CMD_OV_LIM: begin
        // byte transfers are refused; a word write is taken but changes nothing
        ack_nxt = I_CMD.word && pg_ok;                                          // [R10]
        rd_nxt  = {8'h00, sel_a ? lim_a : lim_b};                               // [R12]
      end
      `PTR_CMD_OV_RESP: begin
        ack_nxt = !I_CMD.word;
        rd_nxt  = {8'h00, `PTR_OV_RESP_CODE};                                   // [R9]
      end
      `PTR_CMD_ALRT_MSK: begin
        ack_nxt = !I_CMD.word;
        rd_nxt  = {8'h00, msk_r};
      end
      `PTR_CMD_DAC_CFG: begin
        ack_nxt = !I_CMD.word;
        rd_nxt  = {15'h0000, dac5_r};
      end
      `PTR_CMD_FLT_STAT: begin
        ack_nxt = I_CMD.word && pg_ok && !I_CMD.wr;
        rd_nxt  = {8'h00, O_VIN_UV_FLT, O_IIN_FLT, 2'b00, sel_a ? O_FLT_A : O_FLT_B};
      end
      default: begin
        ack_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_RSP <= '0;
    end else begin
      O_RSP.valid <= I_CMD.valid;
      O_RSP.ack   <= I_CMD.valid && ack_nxt;
      O_RSP.data  <= (I_CMD.valid && !I_CMD.wr && ack_nxt) ? rd_nxt : 16'h0000;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);

  ov_resp_ro_a: assert property (I_CMD.valid && I_CMD.code == `PTR_CMD_OV_RESP && !I_CMD.word && !I_CMD.wr // [R9]
    ##1 1 |-> O_RSP.ack && O_RSP.data == 16'h0080) else $error("overvoltage response not 80h");
  lim_5mv_a: assert property (dac5_r |-> lim_a == 8'hFF && lim_b == 8'hFF) // [R13]
    else $error("5 mv limit not ffh");
  lim_10mv_a: assert property (!dac5_r && vmax_a_r < 8'hF5 |-> lim_a == vmax_a_r + 8'h0A) // [R14]
    else $error("10 mv limit wrong");
  ov_detect_a: assert property (I_TELEM.vout_a >= lim_a |=> O_FLT_A.ov && O_SHDN[0]) // [R15]
    else $error("overvoltage not latched");
  ov_hold_a: assert property (O_FLT_A.ov && run[0] && run_d_r[0] |=> O_FLT_A.ov) // [R1]
    else $error("overvoltage latch dropped");
  ov_clear_a: assert property (O_FLT_A.ov && clr[0] && I_TELEM.vout_a < lim_a |=> !O_FLT_A.ov) // [R17]
    else $error("overvoltage not cleared");
  word_only_a: assert property (I_CMD.valid && I_CMD.code == `PTR_CMD_OV_LIM && !I_CMD.word // [R10]
    |=> O_RSP.valid && !O_RSP.ack) else $error("byte access to limit taken");
  upper_zero_a: assert property (I_CMD.valid && I_CMD.code == `PTR_CMD_OV_LIM // [R12]
    |=> O_RSP.data[15:8] == 8'h00) else $error("limit upper byte nonzero");
  page_all_a: assert property (wr_word && I_CMD.code == `PTR_CMD_VMAX && page_r == `PTR_PAGE_ALL // [R11]
    |=> vmax_a_r == vmax_b_r && vmax_a_r == $past(I_CMD.wdata[7:0])) else $error("ffh page missed");
  warn_only_a: assert property (I_TELEM.iout_a >= `PTR_OC_WRN && I_TELEM.iout_a < `PTR_OC_FLT // [R4]
    && !O_FLT_A.oc |=> O_WARN.oc_a && !O_FLT_A.oc) else $error("warning latched a fault");
  vin_uv_a: assert property (vin_uv_hit |=> O_VIN_UV_FLT && O_SHDN == 2'b11) // [R5]
    else $error("vin undervoltage not latched");
  ov_alert_a: assert property (O_FLT_A.ov && !msk_r[0] |=> !O_HOST_ALERT_LINE_N) // [R16]
    else $error("alert not raised");

  ov_trip_c: cover property (!O_FLT_A.ov ##1 O_FLT_A.ov ##[1:20] clr[0]);
  mode_10mv_c: cover property (!dac5_r && I_CMD.valid && I_CMD.code == `PTR_CMD_OV_LIM);
  both_page_c: cover property (wr_word && I_CMD.code == `PTR_CMD_VMAX && page_r == `PTR_PAGE_ALL);
  alert_mask_c: cover property (O_FLT_A.ov && msk_r[0] ##1 O_HOST_ALERT_LINE_N);
endmodule

// ### tb/ptr_host.sv
// pmbus host model: issues one decoded command at a time on the command port
// assumes the bank answers on i_rsp one clock after the command is taken
`timescale 1ns/1ps
module ptr_host
  import ptr_pkg::*;
(
  input  wire logic     i_clk,
  output ptr_cmd_t      o_cmd,
  input  wire ptr_rsp_t i_rsp
);
  initial o_cmd = '0;

  //------------------------------------------------------------
  // one transfer, answer awaited for a few cycles at most
  //------------------------------------------------------------
  task automatic xfer(input logic wr, input logic word, input logic [7:0] code, input logic [15:0] wd,
                      output logic ok, output logic ack, output logic [15:0] rd);
    int n;
    ok = 1'b0;
    ack = 1'b0;
    rd = 16'h0000;
    @(negedge i_clk);
    o_cmd = {1'b1, wr, word, code, wd};
    @(negedge i_clk);
    // released fields flip so a stale value never passes for a live one
    o_cmd = {3'h0, ~code, ~wd};
    for (n = 0; n < 4 && !ok; n++) begin
      if (i_rsp.valid === 1'b1) begin
        ok = 1'b1;
        ack = i_rsp.ack;
        rd = i_rsp.data;
      end else begin
        @(negedge i_clk);
      end
    end
  endtask
endmodule

// ### tb/ptr_top_tb.sv
// self-checking bench for the protection threshold bank
// assumes ptr_host drives the command port; telemetry and enables driven here
`timescale 1ns/1ps
`include "ptr_regs.svh"
module ptr_top_tb;
  import ptr_pkg::*;
  localparam logic [16:0] ACK = 17'h1_0000;
  localparam logic [16:0] NAK = 17'h0_0000;
  logic       clk;
  logic       nrst;
  ptr_cmd_t   cmd;
  ptr_telem_t tel;
  ptr_telem_t base;
  ptr_telem_t t;
  logic [1:0] en;
  ptr_rsp_t   rsp;
  ptr_flt_t   fa;
  ptr_flt_t   fb;
  logic       vuv;
  logic       iinf;
  ptr_warn_t  warn;
  logic       vok;
  logic [1:0] shdn;
  logic       alert_n;
  int         num_errors;
  int         num_checks;

  ptr_top i_ptr_top (.I_CLK(clk), .I_NRST(nrst), .I_CMD(cmd), .I_TELEM(tel), .I_CH_EN(en), .O_RSP(rsp),
    .O_FLT_A(fa), .O_FLT_B(fb), .O_VIN_UV_FLT(vuv), .O_IIN_FLT(iinf), .O_WARN(warn), .O_VIN_OK(vok),
    .O_SHDN(shdn), .O_HOST_ALERT_LINE_N(alert_n));
  ptr_host i_ptr_host (.i_clk(clk), .o_cmd(cmd), .i_rsp(rsp));

  //------------------------------------------------------------
  // compare, report and transfer helpers
  //------------------------------------------------------------
  task results;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task chk_rsp(input logic [16:0] got, input logic [16:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_pins(input logic [18:0] got, input logic [18:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cmd_x(input logic wr, input logic word, input logic [7:0] code, input logic [15:0] wd,
             input logic [16:0] exp);
    logic        ok;
    logic        ack;
    logic [15:0] d;
    i_ptr_host.xfer(wr, word, code, wd, ok, ack, d);
    if (!ok) begin
      num_errors++;
      results();
    end else begin
      chk_rsp({ack, d}, exp);
    end
  endtask
  function automatic logic [18:0] ex(logic [3:0] a, logic [3:0] b, logic u, logic i, logic [5:0] w,
                                     logic ok, logic [1:0] s);
    return {a, b, u, i, w, ok, s};
  endfunction
  // telemetry sits three cycles so the fault, shutdown and warning registers settle
  task pins(input ptr_telem_t tv, input logic [18:0] exp);
    @(negedge clk);
    tel = tv;
    repeat (3) @(negedge clk);
    chk_pins({fa, fb, vuv, iinf, warn, vok, shdn}, exp);
  endtask
  // latched faults only clear when a channel's run state falls
  task clr;
    @(negedge clk);
    tel = base;
    en = 2'h0;
    repeat (6) @(negedge clk);
    en = 2'h3;
    repeat (6) @(negedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results();
  end

  //------------------------------------------------------------
  // main sequence
  //------------------------------------------------------------
  initial begin
    num_errors = 0;
    num_checks = 0;
    base = '{vout_a: 8'h00, vout_b: 8'h00, iout_a: 8'h00, iout_b: 8'h00, temp_a: 8'h19, temp_b: 8'h19,
             vin_mv: 16'h2EE0, iin_half: 8'h00};
    tel = base;
    en = 2'h3;
    nrst = 1'b0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    cmd_x(1'b0, 1'b0, `PTR_CMD_PAGE, 16'h0000, ACK);
    cmd_x(1'b0, 1'b0, `PTR_CMD_OV_RESP, 16'h0000, ACK | 17'h0_0080);
    cmd_x(1'b0, 1'b1, `PTR_CMD_OV_LIM, 16'h0000, ACK | 17'h0_00FF);
    cmd_x(1'b0, 1'b0, `PTR_CMD_OV_LIM, 16'h0000, NAK);
    cmd_x(1'b1, 1'b1, `PTR_CMD_OV_LIM, 16'h0012, ACK);
    cmd_x(1'b0, 1'b1, `PTR_CMD_OV_LIM, 16'h0000, ACK | 17'h0_00FF);
    cmd_x(1'b1, 1'b0, `PTR_CMD_OV_RESP, 16'h0000, ACK);
    cmd_x(1'b0, 1'b0, `PTR_CMD_OV_RESP, 16'h0000, ACK | 17'h0_0080);
    cmd_x(1'b0, 1'b0, 8'hEE, 16'h0000, NAK);
    $display("test reset_values done");
    cmd_x(1'b1, 1'b0, `PTR_CMD_DAC_CFG, 16'h0000, ACK);
    cmd_x(1'b1, 1'b1, `PTR_CMD_VMAX, 16'h0050, ACK);
    cmd_x(1'b0, 1'b1, `PTR_CMD_OV_LIM, 16'h0000, ACK | 17'h0_005A);
    cmd_x(1'b1, 1'b0, `PTR_CMD_PAGE, 16'h0001, ACK);
    cmd_x(1'b1, 1'b1, `PTR_CMD_VMAX, 16'h0030, ACK);
    cmd_x(1'b0, 1'b1, `PTR_CMD_OV_LIM, 16'h0000, ACK | 17'h0_003A);
    cmd_x(1'b1, 1'b0, `PTR_CMD_PAGE, 16'h00FF, ACK);
    cmd_x(1'b1, 1'b1, `PTR_CMD_VMAX, 16'h0060, ACK);
    cmd_x(1'b0, 1'b1, `PTR_CMD_OV_LIM, 16'h0000, ACK | 17'h0_006A);
    cmd_x(1'b1, 1'b0, `PTR_CMD_PAGE, 16'h0000, ACK);
    cmd_x(1'b1, 1'b1, `PTR_CMD_VMAX, 16'h00F8, ACK);
    cmd_x(1'b0, 1'b1, `PTR_CMD_OV_LIM, 16'h0000, ACK | 17'h0_00FF);
    cmd_x(1'b1, 1'b0, `PTR_CMD_DAC_CFG, 16'h0001, ACK);
    cmd_x(1'b1, 1'b1, `PTR_CMD_VMAX, 16'h0050, ACK);
    cmd_x(1'b0, 1'b1, `PTR_CMD_OV_LIM, 16'h0000, ACK | 17'h0_00FF);
    cmd_x(1'b1, 1'b0, `PTR_CMD_DAC_CFG, 16'h0000, ACK);
    cmd_x(1'b0, 1'b1, `PTR_CMD_OV_LIM, 16'h0000, ACK | 17'h0_005A);
    $display("test ov_limit_paging done");
    t = base;
    t.vout_a = 8'h59;
    pins(t, ex(4'h0, 4'h0, 1'h0, 1'h0, 6'h00, 1'h1, 2'h0));
    t.vout_a = 8'h5A;
    pins(t, ex(4'h8, 4'h0, 1'h0, 1'h0, 6'h00, 1'h1, 2'h1));
    chk_pins({18'h0_0000, alert_n}, 19'h0_0000);
    cmd_x(1'b0, 1'b1, `PTR_CMD_FLT_STAT, 16'h0000, ACK | 17'h0_0008);
    cmd_x(1'b1, 1'b1, `PTR_CMD_FLT_STAT, 16'h0000, NAK);
    // a masked cause must leave the alert line released
    cmd_x(1'b1, 1'b0, `PTR_CMD_ALRT_MSK, 16'h0001, ACK);
    cmd_x(1'b0, 1'b0, `PTR_CMD_ALRT_MSK, 16'h0000, ACK | 17'h0_0001);
    chk_pins({18'h0_0000, alert_n}, 19'h0_0001);
    cmd_x(1'b1, 1'b0, `PTR_CMD_ALRT_MSK, 16'h0000, ACK);
    cmd_x(1'b0, 1'b0, `PTR_CMD_ALRT_MSK, 16'h0000, ACK);
    chk_pins({18'h0_0000, alert_n}, 19'h0_0000);
    pins(base, ex(4'h8, 4'h0, 1'h0, 1'h0, 6'h00, 1'h1, 2'h1));
    clr();
    pins(base, ex(4'h0, 4'h0, 1'h0, 1'h0, 6'h00, 1'h1, 2'h0));
    // second trip cleared through the on bit instead of the enable pin
    t = base;
    t.vout_a = 8'h5A;
    pins(t, ex(4'h8, 4'h0, 1'h0, 1'h0, 6'h00, 1'h1, 2'h1));
    pins(base, ex(4'h8, 4'h0, 1'h0, 1'h0, 6'h00, 1'h1, 2'h1));
    cmd_x(1'b1, 1'b0, `PTR_CMD_OPER, 16'h0000, ACK);
    cmd_x(1'b0, 1'b0, `PTR_CMD_OPER, 16'h0000, ACK);
    cmd_x(1'b1, 1'b0, `PTR_CMD_OPER, 16'h0080, ACK);
    cmd_x(1'b0, 1'b0, `PTR_CMD_OPER, 16'h0000, ACK | 17'h0_0080);
    pins(base, ex(4'h0, 4'h0, 1'h0, 1'h0, 6'h00, 1'h1, 2'h0));
    t = base;
    t.vout_b = 8'h6A;
    pins(t, ex(4'h0, 4'h8, 1'h0, 1'h0, 6'h00, 1'h1, 2'h2));
    clr();
    t = base;
    t.iout_a = 8'h19;
    pins(t, ex(4'h0, 4'h0, 1'h0, 1'h0, 6'h00, 1'h1, 2'h0));
    t.iout_a = 8'h1A;
    pins(t, ex(4'h0, 4'h0, 1'h0, 1'h0, 6'h20, 1'h1, 2'h0));
    t.iout_a = 8'h26;
    pins(t, ex(4'h0, 4'h0, 1'h0, 1'h0, 6'h20, 1'h1, 2'h0));
    t.iout_a = 8'h27;
    pins(t, ex(4'h2, 4'h0, 1'h0, 1'h0, 6'h20, 1'h1, 2'h1));
    clr();
    t = base;
    t.temp_b = 8'h68;
    pins(t, ex(4'h0, 4'h0, 1'h0, 1'h0, 6'h00, 1'h1, 2'h0));
    t.temp_b = 8'h69;
    pins(t, ex(4'h0, 4'h0, 1'h0, 1'h0, 6'h04, 1'h1, 2'h0));
    t.temp_b = 8'h86;
    pins(t, ex(4'h0, 4'h0, 1'h0, 1'h0, 6'h04, 1'h1, 2'h0));
    t.temp_b = 8'h87;
    pins(t, ex(4'h0, 4'h1, 1'h0, 1'h0, 6'h04, 1'h1, 2'h2));
    clr();
    t = base;
    t.vin_mv = 16'h36B0;
    pins(t, ex(4'h0, 4'h0, 1'h0, 1'h0, 6'h00, 1'h1, 2'h0));
    t.vin_mv = 16'h36B1;
    pins(t, ex(4'h0, 4'h0, 1'h0, 1'h0, 6'h01, 1'h1, 2'h0));
    t.vin_mv = 16'h186A;
    pins(t, ex(4'h0, 4'h0, 1'h0, 1'h0, 6'h00, 1'h1, 2'h0));
    t.vin_mv = 16'h1869;
    pins(t, ex(4'h0, 4'h0, 1'h0, 1'h0, 6'h00, 1'h0, 2'h0));
    t.vin_mv = 16'h157C;
    pins(t, ex(4'h0, 4'h0, 1'h0, 1'h0, 6'h00, 1'h0, 2'h0));
    t.vin_mv = 16'h157B;
    pins(t, ex(4'h0, 4'h0, 1'h1, 1'h0, 6'h00, 1'h0, 2'h3));
    clr();
    t = base;
    t.iin_half = 8'h7E;
    pins(t, ex(4'h0, 4'h0, 1'h0, 1'h0, 6'h00, 1'h1, 2'h0));
    t.iin_half = 8'h7F;
    pins(t, ex(4'h0, 4'h0, 1'h0, 1'h1, 6'h02, 1'h1, 2'h3));
    clr();
    pins(base, ex(4'h0, 4'h0, 1'h0, 1'h0, 6'h00, 1'h1, 2'h0));
    $display("test thresholds done");
    results();
  end
endmodule
